// File: hw/mcs_regs.svh
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define MCS_OFF_NORMAL_CFG 8'h00
`define MCS_OFF_HIGH_CFG 8'h04
`define MCS_OFF_LOWPWR_CFG 8'h08
`define MCS_OFF_ASYNC_DIV 8'h0C
`define MCS_OFF_PIN_CTRL 8'h10
`define MCS_OFF_STATUS 8'h14
`define MCS_OFF_DMA_CTRL 8'h18
`define MCS_OFF_DMA_COUNT 8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MCS_CFG_SRC_LSB 24
`define MCS_CFG_CORE_LSB 16
`define MCS_CFG_BUS_LSB 4
`define MCS_CFG_FLASH_LSB 0
`define MCS_ASYNC_ONE_LSB 0
`define MCS_ASYNC_TWO_LSB 8
`define MCS_ST_MODE_LSB 0
`define MCS_ST_STOP_ABORT 4
`define MCS_ST_DMA_DONE 5
`define MCS_ST_CFG_ERR 6
`define MCS_ST_FLASH_OK 7
`define MCS_DMA_ENABLE 0
`define MCS_DMA_DISABLE_ON_DONE 1

// ----------------------------------------------------------------------
// Source codes and reset values
// ----------------------------------------------------------------------
`define MCS_SRC_PLL 4'h6
`define MCS_SRC_FAST_OSC 4'h3
`define MCS_RST_HIGH_CFG 16'h6013
`define MCS_RST_NORMAL_CFG 16'h3001
`define MCS_RST_LOWPWR_CFG 16'h3301
`define MCS_RST_ASYNC_ONE 8'h07
`define MCS_RST_ASYNC_TWO 8'h03

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define MCS_PIN_RATIO 8
`define MCS_PIN_HALF_DIV 4'h3

`endif

// File: hw/mcs_pkg.sv
package mcs_pkg;

  // Power modes, Gray coded along run -> high speed -> stop -> low power run.
  typedef enum logic [1:0] {
    MCS_MODE_RUN = 2'b00,
    MCS_MODE_HIGH = 2'b01,
    MCS_MODE_STOP = 2'b11,
    MCS_MODE_LOWPWR = 2'b10
  } mcs_mode_t;

  // One clock selection set: source and three dividers.
  typedef struct packed {
    logic [3:0] src;
    logic [3:0] core;
    logic [3:0] bus;
    logic [3:0] flash;
  } mcs_cfg_t;

endpackage

// File: hw/mcs_tick_div.sv
`timescale 1ns/1ps

// Divides a stream of enable ticks by div_i + 1 and emits a registered tick.
module mcs_tick_div #(
  parameter int WIDTH = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] div_i,
  output logic tick_o
);

  logic [WIDTH-1:0] count_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("mcs_tick_div: WIDTH must be at least 1");
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // The >= compare lets a shrinking divider take effect without a long wrap.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      count_reg <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (count_reg >= div_i) begin
          count_reg <= '0;
          tick_o <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule

// File: hw/mcs_dma_chan.sv
`timescale 1ns/1ps

// One DMA channel that moves words on peripheral request, clocked off the
// always-on clock so that it keeps working while the core is stopped.
module mcs_dma_chan #(
  parameter int CWIDTH = 16
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic ctrl_wr_i,
  input wire logic enable_i,
  input wire logic count_wr_i,
  input wire logic [CWIDTH-1:0] count_i,
  input wire logic disable_on_done_i,
  output logic enable_o,
  output logic xfer_o,
  output logic done_o,
  output logic [CWIDTH-1:0] remaining_o
);

  logic fire;

  initial begin
    if (CWIDTH < 2) begin
      $error("mcs_dma_chan: CWIDTH must be at least 2");
    end
  end

  // One transfer per request, with a gap so a slow request can drop.
  assign fire = enable_o && req_i && !xfer_o && (remaining_o != '0);

  // ----------------------------------------------------------------------
  // Enable
  // ----------------------------------------------------------------------
  // A software write in the completion cycle wins, so a re-arm is not lost.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      enable_o <= 1'b0;
    end else if (ctrl_wr_i) begin
      enable_o <= enable_i;
    end else if (fire && remaining_o == CWIDTH'(1) && disable_on_done_i) begin
      enable_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Count and strobes
  // ----------------------------------------------------------------------
  // No gating by power mode: the channel serves requests in stop too.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      remaining_o <= '0;
      xfer_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      xfer_o <= fire;
      done_o <= fire && remaining_o == CWIDTH'(1);
      if (count_wr_i) begin
        remaining_o <= count_i;
      end else if (fire) begin
        remaining_o <= remaining_o - 1'b1;
      end
    end
  end

endmodule

// File: hw/mcs_top.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_top
  import mcs_pkg::*;
#(
  parameter int DIV_WIDTH = 4,
  parameter int ASYNC_WIDTH = 8,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic pll_tick_i,
  input wire logic fosc_tick_i,
  input wire logic mode_req_valid_i,
  input wire logic [1:0] mode_req_i,
  output logic mode_ack_o,
  output logic mode_nak_o,
  output logic [1:0] active_mode_o,
  output logic core_tick_o,
  output logic bus_tick_o,
  output logic flash_tick_o,
  output logic async_one_tick_o,
  output logic async_two_tick_o,
  output logic clock_output_pin_o,
  output logic flash_op_allow_o,
  input wire logic dma_req_i,
  output logic dma_xfer_o,
  output logic dma_wake_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  initial begin
    if (DIV_WIDTH != 4) begin
      $error("mcs_top: DIV_WIDTH must be 4 to match the field layout");
    end
    if (ASYNC_WIDTH < 1 || ASYNC_WIDTH > 8) begin
      $error("mcs_top: ASYNC_WIDTH must be 1 to 8");
    end
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 16) begin
      $error("mcs_top: COUNT_WIDTH must be 2 to 16");
    end
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  mcs_cfg_t normal_run_clock_config_reg;
  mcs_cfg_t high_speed_run_clock_config_reg;
  mcs_cfg_t low_power_run_clock_config_reg;
  mcs_cfg_t active_cfg_reg;
  mcs_cfg_t target_cfg;
  mcs_mode_t mode_reg;
  mcs_mode_t req_mode;
  logic [ASYNC_WIDTH-1:0] async_one_div_reg;
  logic [ASYNC_WIDTH-1:0] async_two_div_reg;
  logic pin_enable_reg;
  logic stop_abort_reg;
  logic dma_done_flag_reg;
  logic cfg_err_reg;
  logic disable_on_done_reg;
  logic src_tick;
  logic core_div_tick;
  logic bus_div_tick;
  logic flash_div_tick;
  logic pin_half_tick;
  logic dma_enable;
  logic dma_done;
  logic dma_xfer;
  logic [COUNT_WIDTH-1:0] dma_remaining;
  logic wr_normal;
  logic wr_high;
  logic wr_lowpwr;
  logic wr_async;
  logic wr_pin;
  logic wr_status;
  logic wr_dma_ctrl;
  logic wr_dma_count;
  logic mode_accept;
  logic mode_reject;
  logic [31:0] status_word;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Only two source codes select a running clock; anything else is refused.
  function automatic logic src_valid(input logic [3:0] src);
    src_valid = (src == `MCS_SRC_PLL) || (src == `MCS_SRC_FAST_OSC);
  endfunction

  // Packs a selection set into its register word.
  function automatic logic [31:0] cfg_word(input mcs_cfg_t cfg);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`MCS_CFG_SRC_LSB +: 4] = cfg.src;
    w[`MCS_CFG_CORE_LSB +: 4] = cfg.core;
    w[`MCS_CFG_BUS_LSB +: 4] = cfg.bus;
    w[`MCS_CFG_FLASH_LSB +: 4] = cfg.flash;
    cfg_word = w;
  endfunction

  // Unpacks a register word into a selection set.
  function automatic mcs_cfg_t word_cfg(input logic [31:0] w);
    mcs_cfg_t c;
    c.src = w[`MCS_CFG_SRC_LSB +: 4];
    c.core = w[`MCS_CFG_CORE_LSB +: 4];
    c.bus = w[`MCS_CFG_BUS_LSB +: 4];
    c.flash = w[`MCS_CFG_FLASH_LSB +: 4];
    word_cfg = c;
  endfunction

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign wr_normal = wr_i && addr_i == `MCS_OFF_NORMAL_CFG;
  assign wr_high = wr_i && addr_i == `MCS_OFF_HIGH_CFG;
  assign wr_lowpwr = wr_i && addr_i == `MCS_OFF_LOWPWR_CFG;
  assign wr_async = wr_i && addr_i == `MCS_OFF_ASYNC_DIV;
  assign wr_pin = wr_i && addr_i == `MCS_OFF_PIN_CTRL;
  assign wr_status = wr_i && addr_i == `MCS_OFF_STATUS;
  assign wr_dma_ctrl = wr_i && addr_i == `MCS_OFF_DMA_CTRL;
  assign wr_dma_count = wr_i && addr_i == `MCS_OFF_DMA_COUNT;

  // ----------------------------------------------------------------------
  // Selection sets
  // ----------------------------------------------------------------------
  // Each run mode owns its own set; reset values give the documented frequencies.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      normal_run_clock_config_reg <= mcs_cfg_t'(`MCS_RST_NORMAL_CFG);
      high_speed_run_clock_config_reg <= mcs_cfg_t'(`MCS_RST_HIGH_CFG);
      low_power_run_clock_config_reg <= mcs_cfg_t'(`MCS_RST_LOWPWR_CFG);
    end else begin
      if (wr_normal) begin
        normal_run_clock_config_reg <= word_cfg(wdata_i);
      end
      if (wr_high) begin
        high_speed_run_clock_config_reg <= word_cfg(wdata_i);
      end
      if (wr_lowpwr) begin
        low_power_run_clock_config_reg <= word_cfg(wdata_i);
      end
    end
  end

  // Asynchronous PLL dividers are software owned; mode changes leave them be.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      async_one_div_reg <= ASYNC_WIDTH'(`MCS_RST_ASYNC_ONE);
      async_two_div_reg <= ASYNC_WIDTH'(`MCS_RST_ASYNC_TWO);
      pin_enable_reg <= 1'b0;
    end else begin
      if (wr_async) begin
        async_one_div_reg <= wdata_i[`MCS_ASYNC_ONE_LSB +: ASYNC_WIDTH];
        async_two_div_reg <= wdata_i[`MCS_ASYNC_TWO_LSB +: ASYNC_WIDTH];
      end
      if (wr_pin) begin
        pin_enable_reg <= wdata_i[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode switching
  // ----------------------------------------------------------------------
  assign req_mode = mcs_mode_t'(mode_req_i);

  // Picks the set that belongs to a mode; stop keeps the current set.
  always_comb begin
    case (req_mode)
      MCS_MODE_RUN: target_cfg = normal_run_clock_config_reg;
      MCS_MODE_HIGH: target_cfg = high_speed_run_clock_config_reg;
      MCS_MODE_LOWPWR: target_cfg = low_power_run_clock_config_reg;
      MCS_MODE_STOP: target_cfg = active_cfg_reg;
      default: target_cfg = active_cfg_reg;
    endcase
  end

  // A set naming a dead source would freeze the core, so it is refused.
  assign mode_accept = mode_req_valid_i && src_valid(target_cfg.src);
  assign mode_reject = mode_req_valid_i && !src_valid(target_cfg.src);

  // Source and all dividers move together so no mixed set is ever seen.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_reg <= MCS_MODE_RUN;
      active_cfg_reg <= mcs_cfg_t'(`MCS_RST_NORMAL_CFG);
    end else if (mode_accept) begin
      mode_reg <= req_mode;
      active_cfg_reg <= target_cfg;
    end else if (mode_reg != MCS_MODE_STOP) begin
      case (mode_reg)
        MCS_MODE_RUN: active_cfg_reg <= normal_run_clock_config_reg;
        MCS_MODE_HIGH: active_cfg_reg <= high_speed_run_clock_config_reg;
        MCS_MODE_LOWPWR: active_cfg_reg <= low_power_run_clock_config_reg;
        default: active_cfg_reg <= active_cfg_reg;
      endcase
    end
  end

  // Handshake toward the power mode controller.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_ack_o <= 1'b0;
      mode_nak_o <= 1'b0;
    end else begin
      mode_ack_o <= mode_accept;
      mode_nak_o <= mode_reject;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  // Sticky flags clear by writing one; a new event in the same cycle wins.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stop_abort_reg <= 1'b0;
      dma_done_flag_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      if (mode_accept && req_mode == MCS_MODE_STOP && dma_enable) begin
        stop_abort_reg <= 1'b1;
      end else if (wr_status && wdata_i[`MCS_ST_STOP_ABORT]) begin
        stop_abort_reg <= 1'b0;
      end
      if (dma_done) begin
        dma_done_flag_reg <= 1'b1;
      end else if (wr_status && wdata_i[`MCS_ST_DMA_DONE]) begin
        dma_done_flag_reg <= 1'b0;
      end
      if (mode_reject) begin
        cfg_err_reg <= 1'b1;
      end else if (wr_status && wdata_i[`MCS_ST_CFG_ERR]) begin
        cfg_err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock chain
  // ----------------------------------------------------------------------
  // Source multiplexer; an unknown code gives no ticks at all.
  always_comb begin
    case (active_cfg_reg.src)
      `MCS_SRC_PLL: src_tick = pll_tick_i;
      `MCS_SRC_FAST_OSC: src_tick = fosc_tick_i;
      default: src_tick = 1'b0;
    endcase
  end

  mcs_tick_div #(.WIDTH(DIV_WIDTH)) u_core_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(src_tick),
    .div_i(active_cfg_reg.core),
    .tick_o(core_div_tick)
  );

  // Bus and flash count core ticks, so a core divider change reaches them.
  mcs_tick_div #(.WIDTH(DIV_WIDTH)) u_bus_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(core_div_tick),
    .div_i(active_cfg_reg.bus),
    .tick_o(bus_div_tick)
  );

  mcs_tick_div #(.WIDTH(DIV_WIDTH)) u_flash_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(core_div_tick),
    .div_i(active_cfg_reg.flash),
    .tick_o(flash_div_tick)
  );

  // The asynchronous outputs run straight off the PLL, whatever the mode.
  mcs_tick_div #(.WIDTH(ASYNC_WIDTH)) u_async_one_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(pll_tick_i),
    .div_i(async_one_div_reg),
    .tick_o(async_one_tick_o)
  );

  mcs_tick_div #(.WIDTH(ASYNC_WIDTH)) u_async_two_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(pll_tick_i),
    .div_i(async_two_div_reg),
    .tick_o(async_two_tick_o)
  );

  // Half period of the output pin: four core ticks.
  mcs_tick_div #(.WIDTH(DIV_WIDTH)) u_pin_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(core_div_tick),
    .div_i(DIV_WIDTH'(`MCS_PIN_HALF_DIV)),
    .tick_o(pin_half_tick)
  );

  // The core tick is gated in stop while bus and flash keep feeding the DMA.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      core_tick_o <= 1'b0;
      bus_tick_o <= 1'b0;
      flash_tick_o <= 1'b0;
    end else begin
      core_tick_o <= core_div_tick && mode_reg != MCS_MODE_STOP;
      bus_tick_o <= bus_div_tick;
      flash_tick_o <= flash_div_tick;
    end
  end

  // Pin toggles every four core ticks; held low when disabled to save power.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      clock_output_pin_o <= 1'b0;
    end else if (!pin_enable_reg) begin
      clock_output_pin_o <= 1'b0;
    end else if (pin_half_tick) begin
      clock_output_pin_o <= !clock_output_pin_o;
    end
  end

  // ----------------------------------------------------------------------
  // Mode dependent permissions
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flash_op_allow_o <= 1'b0;
      active_mode_o <= 2'b00;
    end else begin
      flash_op_allow_o <= mode_reg == MCS_MODE_RUN;
      active_mode_o <= mode_reg;
    end
  end

  // ----------------------------------------------------------------------
  // DMA channel
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      disable_on_done_reg <= 1'b0;
    end else if (wr_dma_ctrl) begin
      disable_on_done_reg <= wdata_i[`MCS_DMA_DISABLE_ON_DONE];
    end
  end

  mcs_dma_chan #(.CWIDTH(COUNT_WIDTH)) u_dma (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .req_i(dma_req_i),
    .ctrl_wr_i(wr_dma_ctrl),
    .enable_i(wdata_i[`MCS_DMA_ENABLE]),
    .count_wr_i(wr_dma_count),
    .count_i(wdata_i[COUNT_WIDTH-1:0]),
    .disable_on_done_i(disable_on_done_reg),
    .enable_o(dma_enable),
    .xfer_o(dma_xfer),
    .done_o(dma_done),
    .remaining_o(dma_remaining)
  );

  // Wake follows the last word write, not the serial shifter going idle.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dma_xfer_o <= 1'b0;
      dma_wake_o <= 1'b0;
    end else begin
      dma_xfer_o <= dma_xfer;
      dma_wake_o <= dma_done;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`MCS_ST_MODE_LSB +: 2] = mode_reg;
    status_word[`MCS_ST_STOP_ABORT] = stop_abort_reg;
    status_word[`MCS_ST_DMA_DONE] = dma_done_flag_reg;
    status_word[`MCS_ST_CFG_ERR] = cfg_err_reg;
    status_word[`MCS_ST_FLASH_OK] = mode_reg == MCS_MODE_RUN;
  end

  // Data stand in the cycle after the strobe only; unmapped reads give zero.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (!rd_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      case (addr_i)
        `MCS_OFF_NORMAL_CFG: rdata_o <= cfg_word(normal_run_clock_config_reg);
        `MCS_OFF_HIGH_CFG: rdata_o <= cfg_word(high_speed_run_clock_config_reg);
        `MCS_OFF_LOWPWR_CFG: rdata_o <= cfg_word(low_power_run_clock_config_reg);
        `MCS_OFF_ASYNC_DIV: rdata_o <= {16'h0000,
            8'(async_two_div_reg), 8'(async_one_div_reg)};
        `MCS_OFF_PIN_CTRL: rdata_o <= {31'h0000_0000, pin_enable_reg};
        `MCS_OFF_STATUS: rdata_o <= status_word;
        `MCS_OFF_DMA_CTRL: rdata_o <= {30'h0000_0000, disable_on_done_reg, dma_enable};
        `MCS_OFF_DMA_COUNT: rdata_o <= {16'h0000, 16'(dma_remaining)};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: verification/mcs_top_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Mode link and DMA port checks
// ----------------------------------------------------------------------
module mcs_top_chk
  import mcs_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic mode_req_valid_i,
  input wire logic [1:0] mode_req_i,
  input wire logic mode_ack_o,
  input wire logic mode_nak_o,
  input wire logic [1:0] active_mode_o,
  input wire logic core_tick_o,
  input wire logic flash_op_allow_o,
  input wire logic dma_req_i,
  input wire logic dma_xfer_o,
  input wire logic dma_wake_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // A request is answered one cycle on; held modes skip the switch cycle itself.
  sequence s_answer;
    mode_ack_o || mode_nak_o;
  endsequence
  sequence s_held(logic [1:0] m);
    active_mode_o == m && $past(active_mode_o) == m;
  endsequence
  mode_answer_a: assert property (mode_req_valid_i |=> s_answer)
    else $error("mode request not answered");
  answer_cause_a: assert property (s_answer |-> $past(mode_req_valid_i))
    else $error("mode answer without request");
  ack_mode_a: assert property (mode_ack_o |=> active_mode_o == $past(mode_req_i, 2))
    else $error("accepted mode not active");
  ack_excl_a: assert property (mode_ack_o |-> !mode_nak_o)
    else $error("accept and refuse together");
  stop_core_a: assert property (s_held(MCS_MODE_STOP) |-> !core_tick_o)
    else $error("core ticks in stop");
  high_flash_a: assert property (s_held(MCS_MODE_HIGH) |-> !flash_op_allow_o)
    else $error("flash operations allowed in high speed");
  wake_xfer_a: assert property (dma_wake_o |-> dma_xfer_o)
    else $error("wake not with last word");
  xfer_cause_a: assert property (dma_xfer_o |-> $past(dma_req_i, 2) ##1 !dma_xfer_o)
    else $error("transfer without request or gap");
endmodule

bind mcs_top mcs_top_chk chk_u (.clock_i, .srst_i, .mode_req_valid_i, .mode_req_i,
  .mode_ack_o, .mode_nak_o, .active_mode_o, .core_tick_o, .flash_op_allow_o,
  .dma_req_i, .dma_xfer_o, .dma_wake_o);

// File: verification/mcs_peer_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Far side: clock sources and a transmitting serial port
// ----------------------------------------------------------------------
module mcs_peer_model (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic send_i,
  output logic pll_tick_o,
  output logic fosc_tick_o,
  output logic req_o
);
  // Sources keep fixed rates, so async outputs stay legal in every mode.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pll_tick_o <= 1'b0;
      fosc_tick_o <= 1'b0;
    end else begin
      pll_tick_o <= 1'b1;
      fosc_tick_o <= ~fosc_tick_o;
    end
  end
  // The port asks while told to send; it never waits, so it is no kinder than a deep FIFO.
  assign req_o = send_i & ~srst_i;
endmodule

// File: verification/mcs_top_bench.sv
`timescale 1ns/1ps
module mcs_top_bench;
  import mcs_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0, rd_i = 1'b0, mode_req_valid_i = 1'b0, send = 1'b0;
  logic [1:0] mode_req_i = 2'b00;
  logic [1:0] active_mode_o;
  logic [31:0] rdata_o;
  logic pll_tick_i, fosc_tick_i, dma_req_i, mode_ack_o, mode_nak_o, core_tick_o;
  logic bus_tick_o, flash_tick_o, async_one_tick_o, async_two_tick_o;
  logic clock_output_pin_o, flash_op_allow_o, dma_xfer_o, dma_wake_o;
  int num_errors = 0;
  int checks_done = 0;
  int i, k;
  // ----------------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------------
  always #12.5 clock_i = ~clock_i;
  mcs_top dut_u (.clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pll_tick_i, .fosc_tick_i, .mode_req_valid_i, .mode_req_i, .mode_ack_o, .mode_nak_o,
    .active_mode_o, .core_tick_o, .bus_tick_o, .flash_tick_o, .async_one_tick_o,
    .async_two_tick_o, .clock_output_pin_o, .flash_op_allow_o, .dma_req_i, .dma_xfer_o,
    .dma_wake_o);
  mcs_peer_model peer_u (.clock_i, .srst_i, .send_i(send), .pll_tick_o(pll_tick_i),
    .fosc_tick_o(fosc_tick_i), .req_o(dma_req_i));
  // Every access task starts on a fresh edge, so no strobe is set twice at once.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(rdata_o, e);
  endtask
  // The answer stands one cycle; the reported mode follows it one cycle later.
  task automatic mode(input logic [1:0] m, input logic [1:0] e);
    logic [1:0] a;
    @(posedge clock_i);
    mode_req_i <= m;
    mode_req_valid_i <= 1'b1;
    @(posedge clock_i);
    mode_req_valid_i <= 1'b0;
    @(negedge clock_i);
    a = {mode_ack_o, mode_nak_o};
    @(negedge clock_i);
    chk({a, active_mode_o}, {e == m, e != m, e});
  endtask
  // Counts over 64 cycles, a multiple of every period, so phase cannot matter.
  task automatic meas(input logic [31:0] e);
    int n[6] = '{default: 0};
    logic q;
    repeat (16) @(negedge clock_i);
    q = clock_output_pin_o;
    repeat (64) begin
      @(negedge clock_i);
      n[0] += core_tick_o;
      n[1] += bus_tick_o;
      n[2] += flash_tick_o;
      n[3] += async_one_tick_o;
      n[4] += async_two_tick_o;
      n[5] += (clock_output_pin_o != q);
      q = clock_output_pin_o;
    end
    chk({n[0][7:0], n[1][7:0], n[2][7:0], n[5][7:0]}, e);
    chk({n[3][7:0], n[4][7:0]}, 32'h0000_0810);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Tests; async dividers stay at reset, within every mode's limit
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(8'h00, 32'h0300_0001);
    rd(8'h04, 32'h0600_0013);
    rd(8'h08, 32'h0303_0001);
    rd(8'h20, 32'h0000_0000);
    wr(8'h10, 32'h0000_0001);
    meas(32'h2020_1008);
    chk(flash_op_allow_o, 1'b1);
    $display("reset and run test done");
    mode(MCS_MODE_HIGH, MCS_MODE_HIGH);
    meas(32'h4020_1010);
    chk(flash_op_allow_o, 1'b0);
    wr(8'h04, 32'h0601_0013);
    meas(32'h2010_0808);
    mode(MCS_MODE_RUN, MCS_MODE_RUN);
    meas(32'h2020_1008);
    $display("high speed test done");
    wr(8'h08, 32'h0000_0001);
    mode(MCS_MODE_LOWPWR, MCS_MODE_RUN);
    rd(8'h14, 32'h0000_00C0);
    wr(8'h14, 32'h0000_0040);
    wr(8'h08, 32'h0303_0001);
    mode(MCS_MODE_LOWPWR, MCS_MODE_LOWPWR);
    meas(32'h0808_0402);
    $display("low power test done");
    wr(8'h1C, 32'h0000_0001);
    wr(8'h18, 32'h0000_0003);
    send <= 1'b1;
    for (i = 0; i < 20 && dma_wake_o !== 1'b1; i++) @(negedge clock_i);
    if (i == 20) begin
      num_errors++;
      end_of_test();
    end
    chk(dma_xfer_o, 1'b1);
    @(posedge clock_i);
    send <= 1'b0;
    rd(8'h18, 32'h0000_0002);
    rd(8'h14, 32'h0000_0022);
    wr(8'h14, 32'h0000_0020);
    wr(8'h1C, 32'h0000_0002);
    wr(8'h18, 32'h0000_0001);
    mode(MCS_MODE_STOP, MCS_MODE_STOP);
    rd(8'h14, 32'h0000_0013);
    @(posedge clock_i);
    send <= 1'b1;
    i = 0;
    k = 0;
    repeat (30) begin
      @(negedge clock_i);
      i += dma_xfer_o;
      k += core_tick_o;
    end
    chk({i[7:0], k[7:0]}, 32'h0000_0200);
    @(posedge clock_i);
    send <= 1'b0;
    mode(MCS_MODE_RUN, MCS_MODE_RUN);
    $display("dma and stop test done");
    end_of_test();
  end
endmodule
